/* logic/odcb_consts.vh */
`ifndef ODCB_CONSTS_VH
`define ODCB_CONSTS_VH

// Serial word layout: address first, then data.
`define ODCB_WORD_BITS        16
`define ODCB_ADDR_BITS        5
`define ODCB_DATA_BITS        11
`define ODCB_WORD_LAST        4'hF

// Register addresses.
`define ODCB_ADDR_GLOBAL      5'h00
`define ODCB_ADDR_DIFF        5'h0E
`define ODCB_ADDR_SE          5'h0F

// Global register field positions.
`define ODCB_GLB_EXTREF_BIT   5
`define ODCB_GLB_SWRST_BIT    4
`define ODCB_GLB_DIFF_BIT     8
`define ODCB_GLB_GAIN_BIT     9

// Differential driver register field positions.
`define ODCB_DIFF_DDBL_BIT    0
`define ODCB_DIFF_CDBL_BIT    1
`define ODCB_DIFF_CUR_LO      2
`define ODCB_DIFF_CLKT_LO     4
`define ODCB_DIFF_DATT_LO     7

// Single-ended drive field position and its legal codes.
`define ODCB_SE_DRV_LO        4
`define ODCB_DRV_WEAKER       4'h5
`define ODCB_DRV_DEFAULT      4'h0
`define ODCB_DRV_STRONGER     4'hF
`define ODCB_DRV_MAXIMUM      4'hA

// Reset values of the stored fields.
`define ODCB_RST_GLOBAL       4'h0
`define ODCB_RST_DIFF         10'h000
`define ODCB_RST_SE           4'h0

// Base currents in quarter milliamps.
`define ODCB_CUR_00           6'h0E
`define ODCB_CUR_01           6'h0A
`define ODCB_CUR_10           6'h12
`define ODCB_CUR_11           6'h07

// Termination values in ohms; zero means none.
`define ODCB_TERM_000         9'h000
`define ODCB_TERM_001         9'h12C
`define ODCB_TERM_010         9'h0B9
`define ODCB_TERM_011         9'h073
`define ODCB_TERM_100         9'h096
`define ODCB_TERM_101         9'h064
`define ODCB_TERM_110         9'h050
`define ODCB_TERM_111         9'h041

`endif

/* logic/odcb_sync.v */
`timescale 1ns/1ps
`default_nettype none

// Three-stage pin synchroniser; the output moves only when the last two
// stages agree, so a level caught mid-transition is not passed on.
module odcb_sync (
   input  wire mclk,   // Block clock.
   input  wire rst,    // Asynchronous reset, active high.
   input  wire din,    // Raw pin level.
   output reg  q       // Filtered, synchronised level.
);

   reg stage1Reg;
   reg stage2Reg;
   reg stage3Reg;

   // Shift chain and agreement filter.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         stage1Reg <= 1'b0;
         stage2Reg <= 1'b0;
         stage3Reg <= 1'b0;
         q         <= 1'b0;
      end else begin
         stage1Reg <= din;
         stage2Reg <= stage1Reg;
         stage3Reg <= stage2Reg;
         if (stage2Reg == stage3Reg) begin
            q <= stage3Reg;
         end
      end
   end

endmodule

`default_nettype wire

/* logic/odcb_bank.v */
`timescale 1ns/1ps
`include "odcb_consts.vh"
`default_nettype none

// Behaviour
// - Data-lane doubling bit doubles data current.
// - Clock-lane doubling bit doubles clock current.
// - Two-bit code selects base driver current.
// - Three-bit code selects data-lane termination.
// - Clock-lane termination uses same encoding.
// - Only four single-ended drive codes accepted.
// - Reset pin high means parallel pin control.
// - Reset low: clock pin is serial clock.
// - Parallel: clock pin level selects coarse gain.
// - Enable pin: serial enable or interface select.
// - Data pin: serial data or power-down select.
// - Over-range flag follows full-scale excess.
// - Differential: six lanes carry bit pairs.
// - Single-ended: twelve bits plus output clock.
// - Word is five address, eleven data bits.
// - Software reset clears registers, self-clears.
module odcb_bank (
   input  wire        mclk,                  // Block clock, 40 MHz.
   input  wire        rst,                   // Asynchronous reset.
   input  wire        resetPin,              // Device reset / mode pin.
   input  wire        sclkPin,               // Serial clock or gain pin.
   input  wire        serialDataPin,         // Serial data or power pin.
   input  wire        serialEnablePin,       // Enable, low active serial.
   input  wire        powerDownPin,          // Global power-down pin.
   input  wire [11:0] adcSample,             // Converter word, mclk domain.
   input  wire        adcOverRange,          // Core full-scale comparator.
   output reg         diffModeSel,           // High for differential out.
   output reg         coarseGainSel,         // High for 3.5 dB gain.
   output reg         extRefSel,             // High for external ref.
   output reg  [1:0]  powerDownSel,          // Power-down mode pins.
   output reg         dataFormatSel,         // High for straight binary.
   output reg  [5:0]  dataCurrentQma,        // Data current, 0.25 mA units.
   output reg  [5:0]  clockCurrentQma,       // Clock current, 0.25 mA units.
   output reg  [8:0]  dataTermOhms,          // Data termination, 0 none.
   output reg  [8:0]  clockTermOhms,         // Clock termination, 0 none.
   output reg  [3:0]  cmosDriveSel,          // Single-ended drive code.
   output reg  [5:0]  lanePairTrue,          // Differential lanes, true.
   output reg  [5:0]  lanePairComp,          // Differential lanes, compl.
   output reg         outputClockTrue,       // Output clock, true.
   output reg         outputClockComplement, // Output clock, complement.
   output reg  [11:0] cmosData,              // Single-ended data bits.
   output reg         cmosClock,             // Single-ended output clock.
   output reg         overrangeFlag          // Over-range flag.
);

   wire resetS;
   wire sclkS;
   wire sdataS;
   wire senS;
   wire pdnS;

   reg        sclkPrevReg;
   reg [3:0]  bitCountReg;
   reg [14:0] shiftReg;
   reg [3:0]  globalReg;
   reg [9:0]  diffReg;
   reg [3:0]  seReg;
   reg        phaseReg;
   reg [11:0] sampleReg;

   wire        sclkFall;
   wire [15:0] wordIn;
   wire        wordDone;
   wire [4:0]  wordAddr;
   wire [10:0] wordData;
   wire        softReset;
   wire        serialMode;
   wire [3:0]  drvCode;
   wire        drvLegal;
   wire        modeDiff;
   wire        fmtBinary;
   wire [11:0] sampleCoded;
   wire [5:0]  baseCur;
   wire [6:0]  baseCurX2;

   // Each pin goes through its own synchroniser.
   odcb_sync uSyncReset (
      .mclk (mclk),
      .rst  (rst),
      .din  (resetPin),
      .q    (resetS)
   );

   odcb_sync uSyncSclk (
      .mclk (mclk),
      .rst  (rst),
      .din  (sclkPin),
      .q    (sclkS)
   );

   odcb_sync uSyncSdata (
      .mclk (mclk),
      .rst  (rst),
      .din  (serialDataPin),
      .q    (sdataS)
   );

   odcb_sync uSyncSen (
      .mclk (mclk),
      .rst  (rst),
      .din  (serialEnablePin),
      .q    (senS)
   );

   odcb_sync uSyncPdn (
      .mclk (mclk),
      .rst  (rst),
      .din  (powerDownPin),
      .q    (pdnS)
   );

   // Decodes a base current code into quarter milliamps.
   function [5:0] baseCurrent;
      input [1:0] code;
      begin
         case (code)
            2'h0:    baseCurrent = `ODCB_CUR_00;
            2'h1:    baseCurrent = `ODCB_CUR_01;
            2'h2:    baseCurrent = `ODCB_CUR_10;
            default: baseCurrent = `ODCB_CUR_11;
         endcase
      end
   endfunction

   // Decodes a termination code into ohms, zero meaning none.
   function [8:0] termOhms;
      input [2:0] code;
      begin
         case (code)
            3'h0:    termOhms = `ODCB_TERM_000;
            3'h1:    termOhms = `ODCB_TERM_001;
            3'h2:    termOhms = `ODCB_TERM_010;
            3'h3:    termOhms = `ODCB_TERM_011;
            3'h4:    termOhms = `ODCB_TERM_100;
            3'h5:    termOhms = `ODCB_TERM_101;
            3'h6:    termOhms = `ODCB_TERM_110;
            default: termOhms = `ODCB_TERM_111;
         endcase
      end
   endfunction

   // The serial port is live only while the reset pin is low.
   assign serialMode = ~resetS;
   assign sclkFall   = serialMode & ~senS & sclkPrevReg &
                       ~sclkS;
   assign wordIn     = {shiftReg, sdataS};
   assign wordDone   = sclkFall & (bitCountReg == `ODCB_WORD_LAST);
   assign wordAddr   = wordIn[15:11];
   assign wordData   = wordIn[10:0];
   assign softReset  = wordDone & (wordAddr == `ODCB_ADDR_GLOBAL) &
                       wordData[`ODCB_GLB_SWRST_BIT];
   assign drvCode    = wordData[`ODCB_SE_DRV_LO+3:`ODCB_SE_DRV_LO];
   assign drvLegal   = (drvCode == `ODCB_DRV_WEAKER)   |
                       (drvCode == `ODCB_DRV_DEFAULT)  |
                       (drvCode == `ODCB_DRV_STRONGER) |
                       (drvCode == `ODCB_DRV_MAXIMUM);

   // Base current and its double; the largest double still fits six bits.
   assign baseCur    = baseCurrent(diffReg[3:2]);
   assign baseCurX2  = {baseCur, 1'b0};

   // Shifter: a bit on each falling serial clock edge, words of sixteen,
   // leftover bits dropped when the enable goes high.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         sclkPrevReg <= 1'b0;
         bitCountReg <= 4'h0;
         shiftReg    <= 15'h0000;
      end else begin
         sclkPrevReg <= sclkS;
         if (~serialMode | senS) begin
            bitCountReg <= 4'h0;
         end else if (sclkFall) begin
            bitCountReg <= bitCountReg + 4'h1;
            shiftReg    <= wordIn[14:0];
         end
      end
   end

   // Register file; the reset pin high and a software reset both clear it.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         globalReg <= `ODCB_RST_GLOBAL;
         diffReg   <= `ODCB_RST_DIFF;
         seReg     <= `ODCB_RST_SE;
      end else if (resetS | softReset) begin
         globalReg <= `ODCB_RST_GLOBAL;
         diffReg   <= `ODCB_RST_DIFF;
         seReg     <= `ODCB_RST_SE;
      end else if (wordDone) begin
         case (wordAddr)
            `ODCB_ADDR_GLOBAL: begin
               globalReg <= {wordData[`ODCB_GLB_GAIN_BIT],
                             wordData[`ODCB_GLB_DIFF_BIT],
                             wordData[`ODCB_GLB_EXTREF_BIT], 1'b0};
            end
            `ODCB_ADDR_DIFF: begin
               diffReg <= wordData[9:0];
            end
            `ODCB_ADDR_SE: begin
               if (drvLegal) begin
                  seReg <= drvCode;
               end
            end
            default: begin
               globalReg <= globalReg;
            end
         endcase
      end
   end

   // Pin-or-register mode selection.
   assign modeDiff  = serialMode ? globalReg[2] : senS;
   assign fmtBinary = serialMode ? 1'b0 : senS;
   assign sampleCoded = fmtBinary ? adcSample :
                        {~adcSample[11], adcSample[10:0]};

   // Mode and driver setting outputs, registered.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         diffModeSel     <= 1'b0;
         coarseGainSel   <= 1'b0;
         extRefSel       <= 1'b0;
         powerDownSel    <= 2'h0;
         dataFormatSel   <= 1'b0;
         dataCurrentQma  <= 6'h00;
         clockCurrentQma <= 6'h00;
         dataTermOhms    <= 9'h000;
         clockTermOhms   <= 9'h000;
         cmosDriveSel    <= 4'h0;
         overrangeFlag   <= 1'b0;
      end else begin
         diffModeSel   <= modeDiff;
         dataFormatSel <= fmtBinary;
         overrangeFlag <= adcOverRange;
         if (serialMode) begin
            coarseGainSel <= globalReg[3];
            extRefSel     <= globalReg[1];
            powerDownSel  <= {pdnS, 1'b0};
         end else begin
            coarseGainSel <= sclkS;
            extRefSel     <= 1'b0;
            powerDownSel  <= {pdnS, sdataS};
         end
         if (modeDiff) begin
            dataCurrentQma <= diffReg[`ODCB_DIFF_DDBL_BIT] ?
               baseCurX2[5:0] : baseCur;
            clockCurrentQma <= diffReg[`ODCB_DIFF_CDBL_BIT] ?
               baseCurX2[5:0] : baseCur;
            dataTermOhms  <= termOhms(diffReg[9:7]);
            clockTermOhms <= termOhms(diffReg[6:4]);
            cmosDriveSel  <= `ODCB_DRV_DEFAULT;
         end else begin
            dataCurrentQma  <= 6'h00;
            clockCurrentQma <= 6'h00;
            dataTermOhms    <= 9'h000;
            clockTermOhms   <= 9'h000;
            cmosDriveSel    <= seReg;
         end
      end
   end

   // Output phase: a sample is taken every other cycle and both halves
   // of the output clock period are used in differential mode.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         phaseReg              <= 1'b0;
         sampleReg             <= 12'h000;
         outputClockTrue       <= 1'b0;
         outputClockComplement <= 1'b0;
         cmosClock             <= 1'b0;
         cmosData              <= 12'h000;
      end else begin
         phaseReg <= ~phaseReg;
         if (~phaseReg) begin
            sampleReg <= sampleCoded;
         end
         if (modeDiff) begin
            outputClockTrue       <= ~phaseReg;
            outputClockComplement <= phaseReg;
            cmosClock             <= 1'b0;
            cmosData              <= 12'h000;
         end else begin
            outputClockTrue       <= 1'b0;
            outputClockComplement <= 1'b0;
            cmosClock             <= ~phaseReg;
            if (~phaseReg) begin
               cmosData <= sampleCoded;
            end
         end
      end
   end

   // Six lanes, each carrying an even bit then its odd neighbour.
   genvar lane;
   generate
      for (lane = 0; lane < 6; lane = lane + 1) begin : gLane
         always @(posedge mclk or posedge rst) begin
            if (rst) begin
               lanePairTrue[lane] <= 1'b0;
               lanePairComp[lane] <= 1'b0;
            end else if (modeDiff) begin
               lanePairTrue[lane] <= phaseReg ?
                  sampleReg[2*lane+1] : sampleCoded[2*lane];
               lanePairComp[lane] <= phaseReg ?
                  ~sampleReg[2*lane+1] : ~sampleCoded[2*lane];
            end else begin
               lanePairTrue[lane] <= 1'b0;
               lanePairComp[lane] <= 1'b0;
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

/* tb/odcb_bank_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

// Checks the pin-mode and output relations of the bank at its ports.
module odcb_bank_asserts (
   input wire logic        mclk,            // Block clock.
   input wire logic        rst,             // Reset.
   input wire logic        resetPin,        // Mode pin.
   input wire logic        sclkPin,         // Clock or gain pin.
   input wire logic        serialDataPin,   // Data or power pin.
   input wire logic        serialEnablePin, // Enable or mode pin.
   input wire logic        powerDownPin,    // Power-down pin.
   input wire logic        adcOverRange,    // Comparator level.
   input wire logic        diffModeSel,     // Output mode.
   input wire logic        coarseGainSel,   // Gain select.
   input wire logic        extRefSel,       // Reference select.
   input wire logic [1:0]  powerDownSel,    // Power-down select.
   input wire logic [5:0]  dataCurrentQma,  // Data current.
   input wire logic [8:0]  dataTermOhms,    // Data termination.
   input wire logic [3:0]  cmosDriveSel,    // Drive code.
   input wire logic [5:0]  lanePairTrue,    // Lanes.
   input wire logic        outputClockTrue, // Output clock.
   input wire logic [11:0] cmosData,        // Single-ended data.
   input wire logic        dataFormatSel,   // Data format.
   input wire logic [5:0]  lanePairComp,    // Lanes, complement.
   input wire logic        outputClockComplement, // Clock complement.
   input wire logic        cmosClock,       // Single-ended clock.
   input wire logic        overrangeFlag    // Over-range flag.
);
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (rst);

   ovr_delay_a:
   assert property (!$past(rst) |-> overrangeFlag == $past(adcOverRange))
      else $error("over-range flag lags wrongly");
   gain_pin_a:
   assert property ((resetPin && $stable(sclkPin))[*8]
      |-> coarseGainSel == sclkPin && !extRefSel)
      else $error("gain pin level not applied");
   mode_pin_a:
   assert property ((resetPin && $stable(serialEnablePin))[*8]
      |-> diffModeSel == serialEnablePin)
      else $error("enable pin level not applied");
   pdn_pin_a:
   assert property ((resetPin && $stable({powerDownPin, serialDataPin}))[*8]
      |-> powerDownSel == {powerDownPin, serialDataPin})
      else $error("power-down pins not applied");
   cmos_quiet_a:
   assert property (diffModeSel[*4] |-> cmosDriveSel == 4'h0
      && cmosData == 12'h000)
      else $error("single-ended side active in differential mode");
   diff_quiet_a:
   assert property (!diffModeSel[*4] |-> dataCurrentQma == 6'h00
      && dataTermOhms == 9'h000 && lanePairTrue == 6'h00)
      else $error("differential side active in single-ended mode");
   cur_legal_a:
   assert property (dataCurrentQma inside {6'h00, 6'h0E, 6'h0A, 6'h12,
      6'h07, 6'h1C, 6'h14, 6'h24})
      else $error("data current outside its table");
   term_legal_a:
   assert property (dataTermOhms inside {9'h000, 9'h12C, 9'h0B9, 9'h073,
      9'h096, 9'h064, 9'h050, 9'h041})
      else $error("data termination outside its table");
   drv_legal_a:
   assert property (cmosDriveSel inside {4'h0, 4'h5, 4'hA, 4'hF})
      else $error("illegal drive code stored");
   clk_toggle_a:
   assert property (diffModeSel[*3]
      |-> outputClockTrue != $past(outputClockTrue))
      else $error("output clock not toggling");
   pair_comp_a:
   assert property (diffModeSel |-> lanePairComp == ~lanePairTrue
      && outputClockComplement == !outputClockTrue)
      else $error("complement outputs do not mirror true outputs");
   cmos_clock_a:
   assert property (!diffModeSel[*3] |-> cmosClock != $past(cmosClock))
      else $error("single-ended clock not toggling");
   fmt_pin_a:
   assert property ((resetPin && $stable(serialEnablePin))[*8]
      |-> dataFormatSel == serialEnablePin)
      else $error("format pin level not applied");
endmodule

bind odcb_bank odcb_bank_asserts odcb_bank_asserts_i (.mclk, .rst,
   .resetPin, .sclkPin, .serialDataPin, .serialEnablePin, .powerDownPin,
   .adcOverRange, .diffModeSel, .coarseGainSel, .extRefSel, .powerDownSel,
   .dataCurrentQma, .dataTermOhms, .cmosDriveSel, .lanePairTrue,
   .outputClockTrue, .cmosData, .overrangeFlag, .dataFormatSel,
   .lanePairComp, .outputClockComplement, .cmosClock);
`default_nettype wire

/* tb/odcb_host.sv */
`timescale 1ns/1ps
`default_nettype none

// Host side of the three-wire port; released lines rest at pull levels.
module odcb_host (
   output var logic sclkPin,         // Serial clock, rests low.
   output var logic serialDataPin,   // Serial data, rests low.
   output var logic serialEnablePin  // Enable, low active, rests high.
);
   // Lines start released.
   initial begin
      sclkPin = 1'b0;
      serialDataPin = 1'b0;
      serialEnablePin = 1'b1;
   end

   // Sends the top nBits of a word, first bit first, one per falling clock.
   task automatic sendBits(input logic [15:0] word, input int nBits);
      int i;
      serialEnablePin = 1'b0;
      #100;
      for (i = 15; i > 15 - nBits; i--) begin
         sclkPin = 1'b1;
         serialDataPin = word[i];
         #100;
         sclkPin = 1'b0;
         #100;
      end
      serialEnablePin = 1'b1;
      serialDataPin = 1'b0;
      #200;
   endtask

   // Holds the three pins as static levels for pin control.
   task automatic setLevels(input logic c, input logic d, input logic e);
      sclkPin = c;
      serialDataPin = d;
      serialEnablePin = e;
   endtask
endmodule
`default_nettype wire

/* tb/odcb_bank_bench.sv */
`timescale 1ns/1ps
`include "odcb_consts.vh"
`default_nettype none

module odcb_bank_bench;
   logic        mclk, rst, resetPin, powerDownPin, adcOverRange;
   logic [11:0] adcSample;
   logic        diffModeSel, coarseGainSel, extRefSel;
   logic [1:0]  powerDownSel;
   logic [5:0]  dataCurrentQma, clockCurrentQma;
   logic [8:0]  dataTermOhms, clockTermOhms;
   logic [3:0]  cmosDriveSel;
   wire         sclkPin, serialDataPin, serialEnablePin;
   logic [38:0] expQ [$];
   logic [38:0] expV, e;
   logic [10:0] d;
   logic [31:0] seed = 32'h4638E409;
   int          i;
   int          fails = 0;
   int          cmpCount = 0;
   event        chkEv;
   logic [5:0]  curTab [4] = '{`ODCB_CUR_00, `ODCB_CUR_01, `ODCB_CUR_10,
      `ODCB_CUR_11};
   logic [8:0]  trmTab [8] = '{`ODCB_TERM_000, `ODCB_TERM_001, `ODCB_TERM_010,
      `ODCB_TERM_011, `ODCB_TERM_100, `ODCB_TERM_101, `ODCB_TERM_110,
      `ODCB_TERM_111};
   logic [3:0]  drvTab [4] = '{`ODCB_DRV_WEAKER, `ODCB_DRV_DEFAULT,
      `ODCB_DRV_STRONGER, `ODCB_DRV_MAXIMUM};

   odcb_bank odcb_bank_i (.mclk, .rst, .resetPin, .sclkPin, .serialDataPin,
      .serialEnablePin, .powerDownPin, .adcSample, .adcOverRange,
      .diffModeSel, .coarseGainSel, .extRefSel, .powerDownSel,
      .dataFormatSel(), .dataCurrentQma, .clockCurrentQma, .dataTermOhms,
      .clockTermOhms, .cmosDriveSel, .lanePairTrue(), .lanePairComp(),
      .outputClockTrue(), .outputClockComplement(), .cmosData(),
      .cmosClock(), .overrangeFlag());
   odcb_host odcb_host_i (.sclkPin, .serialDataPin, .serialEnablePin);

   // Xorshift step; callers read bits of the seed afterwards.
   function automatic void step();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
   endfunction

   // Packs mode bits, currents, terminations and drive code.
   function automatic logic [38:0] mk(logic [4:0] m, logic [5:0] dc, cc,
      logic [8:0] dt, ct, logic [3:0] dr);
      return {m, dc, cc, dt, ct, dr};
   endfunction

   // Lets a write settle, then queues what the outputs must show.
   task automatic expectNow(input logic [38:0] x);
      repeat (12) @(posedge mclk);
      #1;
      expQ.push_back(x);
      -> chkEv;
   endtask

   task automatic finishTest();
      $display("comparisons %0d mismatches %0d", cmpCount, fails);
      if (fails == 0 && cmpCount > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   always #12.5 mclk = ~mclk;

   // Random converter words and over-range levels after each edge.
   always @(posedge mclk) begin
      #1;
      step();
      adcSample = seed[11:0];
      adcOverRange = seed[31];
   end

   // Takes the oldest queued note and compares it with the outputs.
   always @(chkEv) begin
      expV = expQ.pop_front();
      cmpCount++;
      if (expV !== {diffModeSel, coarseGainSel, extRefSel, powerDownSel,
         dataCurrentQma, clockCurrentQma, dataTermOhms, clockTermOhms,
         cmosDriveSel}) begin
         fails++;
         $display("wrong value outputs expected %h seen %h", expV,
            {diffModeSel, coarseGainSel, extRefSel, powerDownSel,
            dataCurrentQma, clockCurrentQma, dataTermOhms, clockTermOhms,
            cmosDriveSel});
      end
   end

   // Cuts a hung run short.
   initial begin
      #2000000;
      fails++;
      finishTest();
   end

   // Main sequence.
   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      resetPin = 1'b0;
      powerDownPin = 1'b0;
      adcSample = 12'h000;
      adcOverRange = 1'b0;
      repeat (8) @(posedge mclk);
      #1;
      rst = 1'b0;
      resetPin = 1'b1;
      #200;
      resetPin = 1'b0;
      expectNow('0);
      $display("test reset done");
      // Differential mode, every termination code and current code.
      odcb_host_i.sendBits({`ODCB_ADDR_GLOBAL, 11'h100}, 16);
      for (i = 0; i < 8; i++) begin
         step();
         d = {1'b0, i[2:0], 3'(7 - i), i[1:0], seed[1:0]};
         e = mk(5'h10, curTab[i % 4] << seed[0], curTab[i % 4] << seed[1],
            trmTab[i], trmTab[7 - i], '0);
         odcb_host_i.sendBits({`ODCB_ADDR_DIFF, d}, 16);
         expectNow(e);
      end
      $display("test differential done");
      // Single-ended mode with gain and external reference, each drive code.
      odcb_host_i.sendBits({`ODCB_ADDR_GLOBAL, 11'h220}, 16);
      for (i = 0; i < 4; i++) begin
         d = {3'h0, drvTab[i], 4'h0};
         odcb_host_i.sendBits({`ODCB_ADDR_SE, d}, 16);
         e = mk(5'h0C, '0, '0, '0, '0, drvTab[i]);
         expectNow(e);
      end
      // Illegal code, unmapped address and a short word change nothing.
      odcb_host_i.sendBits({`ODCB_ADDR_SE, 11'h030}, 16);
      odcb_host_i.sendBits({5'h05, 11'h7FF}, 16);
      odcb_host_i.sendBits({`ODCB_ADDR_SE, 11'h0F0}, 10);
      expectNow(mk(5'h0C, '0, '0, '0, '0, `ODCB_DRV_MAXIMUM));
      $display("test drive done");
      // Software reset clears everything and lets later writes land.
      odcb_host_i.sendBits({`ODCB_ADDR_GLOBAL, 11'h010}, 16);
      expectNow('0);
      odcb_host_i.sendBits({`ODCB_ADDR_GLOBAL, 11'h100}, 16);
      e = mk(5'h10, `ODCB_CUR_00, `ODCB_CUR_00, '0, '0, '0);
      expectNow(e);
      $display("test soft reset done");
      // Pin control with the mode pin held high.
      odcb_host_i.setLevels(1'b1, 1'b1, 1'b1);
      resetPin = 1'b1;
      e = mk(5'h19, `ODCB_CUR_00, `ODCB_CUR_00, '0, '0, '0);
      expectNow(e);
      odcb_host_i.setLevels(1'b0, 1'b0, 1'b0);
      powerDownPin = 1'b1;
      expectNow(mk(5'h02, '0, '0, '0, '0, '0));
      $display("test parallel done");
      finishTest();
   end
endmodule
`default_nettype wire
